//--- bench/scpwm_sync_master_model.sv
// Purpose: Frequency-sync master seen from a slave: shared clock and sync pulse
// Assumes: Oscillator period of div_p fast clocks
// Notes:   Clock stands still and sync sits at its pull-down level when not running
`timescale 1ns/1ps
module scpwm_sync_master_model
#(
    parameter int div_p = 12
)
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control from bench
    input  wire logic run_i,
    input  wire logic fire_i,
    // Shared pins
    output logic      clk_pin_o,
    output logic      sync_pin_o
);
    logic [4:0] div_reg;
    logic [4:0] sync_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            div_reg   <= 5'h00;
            clk_pin_o <= 1'b0;
        end
        else
        begin
            div_reg   <= (div_reg == 5'(div_p - 1)) ? 5'h00 : div_reg + 5'h01;
            clk_pin_o <= (div_reg < 5'(div_p / 2));
        end
    end

    // Held one oscillator period, well beyond the slave's filter
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
            sync_reg <= 5'h00;
        else if (fire_i)
            sync_reg <= 5'(div_p);
        else if (sync_reg != 5'h00)
            sync_reg <= sync_reg - 5'h01;
    end

    assign sync_pin_o = (sync_reg != 5'h00);
endmodule

//--- bench/tb_top.sv
// Purpose: Self-checking bench for the system clock PWM block
// Assumes: 100 MHz clock, Wishbone classic master tasks
// Notes:   Pulse widths are measured in fast clock cycles
`timescale 1ns/1ps
`include "scpwm_regs.svh"
module tb_top;
    localparam int T = `SCPWM_OSC_DIV;
    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic        ce_i        = 1'b1;
    logic        sleep_i     = 1'b0;
    logic        cyc_i       = 1'b0;
    logic        stb_i       = 1'b0;
    logic        we_i        = 1'b0;
    logic [31:0] adr_i       = 32'h0;
    logic [3:0]  sel_i       = 4'h0;
    logic [31:0] dat_i       = 32'h0;
    logic        m_run       = 1'b0;
    logic        m_fire      = 1'b0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        pin;
    logic        sclk_o;
    logic        sclk_oe_n;
    logic        sync_o;
    logic        sync_oe_n;
    logic        m_clk;
    logic        m_sync;
    wire         sclk_w      = sclk_oe_n ? m_clk : sclk_o;
    wire         sync_w      = sync_oe_n ? m_sync : sync_o;
    int          miscompares = 0;
    int          compares    = 0;
    int          cycles      = 0;

    always #5 clk_i = ~clk_i;

    scpwm_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .sleep_i(sleep_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .clock_out_pin_o(pin),
        .shared_clock_pin_i(sclk_w), .shared_clock_pin_o(sclk_o),
        .shared_clock_pin_oe_n_o(sclk_oe_n), .sync_pin_i(sync_w), .sync_pin_o(sync_o),
        .sync_pin_oe_n_o(sync_oe_n));

    scpwm_sync_master_model #(.div_p(T)) master_u (.clk_i(clk_i), .rst_i(rst_i),
        .run_i(m_run), .fire_i(m_fire), .clk_pin_o(m_clk), .sync_pin_o(m_sync));

    task automatic tally_and_finish();
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {24'h0, a};
        dat_i <= d;
        sel_i <= 4'hf;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 100);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        check(n < 100, "no bus answer");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic wait_lvl(input logic v, output int n);
        n = 0;
        while (pin !== v && n < 20000)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, `SCPWM_OFS_PERIOD, 32'h0, q);
        check(q === 32'hff, "period reset");
        wb(1'b0, `SCPWM_OFS_DUTY, 32'h0, q);
        check(q === 32'h0, "duty reset");
        wr(`SCPWM_OFS_PHASE, 32'h5a);
        wb(1'b0, `SCPWM_OFS_PHASE, 32'h0, q);
        check(q === 32'h5a, "phase readback");
        wr(8'h40, 32'h77);
        wb(1'b0, 8'h40, 32'h0, q);
        check(q === 32'h0, "unmapped read");
    endtask

    task automatic t_period(input logic [1:0] ps, input int f);
        int n;
        int hi;
        int lo;
        wr(`SCPWM_OFS_PERIOD, 32'h3);
        wr(`SCPWM_OFS_DUTY, 32'h1);
        wr(`SCPWM_OFS_CTRL, {29'h0, 1'b1, ps});
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, hi);
        wait_lvl(1'b1, lo);
        check(hi == T * f, "high time");
        check(hi + lo == 4 * T * f, "period length");
        check(lo > 0, "low remainder");
    endtask

    task automatic t_latch_sleep();
        logic [31:0] s1;
        logic [31:0] s2;
        int          n;
        time         t0;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        t0 = $time;
        wr(`SCPWM_OFS_DUTY, 32'h2);
        wait_lvl(1'b0, n);
        check($time - t0 == 10 * T, "duty changed mid period");
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        check(n == 2 * T, "duty not latched at rollover");
        wait_lvl(1'b1, n);
        sleep_i <= 1'b1;
        wb(1'b0, `SCPWM_OFS_STAT, 32'h0, s1);
        repeat (40) @(posedge clk_i);
        wb(1'b0, `SCPWM_OFS_STAT, 32'h0, s2);
        check(s1[7:0] === s2[7:0], "counter moved in sleep");
        check(pin === 1'b1, "pin level lost in sleep");
        sleep_i <= 1'b0;
        ce_i    <= 1'b0;
        repeat (3 * T) @(posedge clk_i);
        check(pin === 1'b1, "pin moved with clock enable low");
        ce_i    <= 1'b1;
        wr(`SCPWM_OFS_CTRL, 32'h0);
        repeat (3 * T) @(posedge clk_i);
        check(pin === 1'b0, "output while stopped");
    endtask

    task automatic t_master();
        int n;
        wr(`SCPWM_OFS_MODE, 32'h1);
        wr(`SCPWM_OFS_CTRL, 32'h4);
        check(sclk_oe_n === 1'b0 && sync_oe_n === 1'b0, "master pins idle");
        n = 0;
        while (sclk_o !== 1'b0 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        while (sclk_o !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        while (sclk_o === 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        check(n == `SCPWM_OSC_HALF, "shared clock high time");
        n = 0;
        while (sync_o !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        check(n < 100, "no sync pulse");
        wr(`SCPWM_OFS_MODE, 32'h0);
        @(posedge clk_i);
        check(sclk_oe_n === 1'b1 && sync_oe_n === 1'b1, "pins driven alone");
    endtask

    task automatic t_slave();
        int n;
        wr(`SCPWM_OFS_CTRL, 32'h0);
        wr(`SCPWM_OFS_PERIOD, 32'hff);
        wr(`SCPWM_OFS_DUTY, 32'h2);
        wr(`SCPWM_OFS_PHASE, 32'h3);
        wr(`SCPWM_OFS_MODE, 32'h2);
        m_run <= 1'b1;
        wr(`SCPWM_OFS_CTRL, 32'h4);
        repeat (100) @(posedge clk_i);
        wr(`SCPWM_OFS_DUTY, 32'h5);
        m_fire <= 1'b1;
        @(posedge clk_i);
        m_fire <= 1'b0;
        wait_lvl(1'b1, n);
        check(n > 2 * T && n < 5 * T, "phase delay");
        wait_lvl(1'b0, n);
        check(n == 5 * T, "duty not latched by sync");
        m_run <= 1'b0;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_period(2'h0, 1);
        t_period(2'h1, 4);
        t_period(2'h2, 16);
        t_period(2'h3, 16);
        t_period(2'h0, 1);
        t_latch_sleep();
        t_master();
        t_slave();
        tally_and_finish();
    end
endmodule

//--- hdl/scpwm_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_i
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module scpwm_pin_sync
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Pin and result
    input  wire logic pin_i,
    output logic      level_o
);
    logic [2:0] stage_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stage_reg <= 3'h0;
            level_o   <= 1'b0;
        end
        else if (ce_i)
        begin
            stage_reg <= {stage_reg[1:0], pin_i};
            if (stage_reg[1] == stage_reg[2])
                level_o <= stage_reg[2];
        end
    end
endmodule

//--- hdl/scpwm_pkg.sv
// Purpose: Types shared by the system clock PWM files
// Assumes: Offsets and counts live in scpwm_regs.svh
// Notes:   Nothing here is imported; use scpwm_pkg::name
package scpwm_pkg;

    typedef enum logic [1:0]
    {
        MODE_ALONE  = 2'h0,
        MODE_MASTER = 2'h1,
        MODE_SLAVE  = 2'h2
    } scpwm_mode_e;

    typedef enum logic [2:0]
    {
        ST_STOP  = 3'h1,
        ST_RUN   = 3'h2,
        ST_PHASE = 3'h4
    } scpwm_state_e;

    typedef struct packed
    {
        logic       run;
        logic [1:0] ps_sel;
    } scpwm_ctrl_s;

endpackage

//--- hdl/scpwm_prescaler.sv
// Purpose: Timer prescaler, divides oscillator ticks by 1, 4 or 16
// Assumes: osc_tick_i is a one-cycle pulse
// Notes:   Count is cleared while the timer is stopped
`timescale 1ns/1ps
module scpwm_prescaler
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       en_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [1:0] ps_sel_i,
    input  wire logic       osc_tick_i,
    // Result
    output logic            tick_o
);
    logic [3:0] cnt_reg;
    logic [3:0] limit;

    assign limit  = ps_sel_i[1] ? 4'hf : (ps_sel_i[0] ? 4'h3 : 4'h0);
    assign tick_o = run_i && osc_tick_i && (cnt_reg >= limit);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_reg <= 4'h0;
        else if (en_i)
        begin
            if (!run_i || tick_o)
                cnt_reg <= 4'h0;
            else if (osc_tick_i)
                cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule

//--- hdl/scpwm_regs.svh
// Purpose: Register offsets, fields, reset values and timing counts
// Assumes: Classic Wishbone, 32-bit data, byte addresses
// Notes:   Definitions only
`ifndef SCPWM_REGS_SVH
`define SCPWM_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCPWM_OFS_CTRL   8'h00
`define SCPWM_OFS_PERIOD 8'h04
`define SCPWM_OFS_DUTY   8'h08
`define SCPWM_OFS_PHASE  8'h0c
`define SCPWM_OFS_MODE   8'h10
`define SCPWM_OFS_STAT   8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCPWM_CTRL_RUN   2
`define SCPWM_CTRL_PSHI  1
`define SCPWM_CTRL_PSLO  0
`define SCPWM_STAT_OUT   8
`define SCPWM_STAT_PHS   9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCPWM_RST_CTRL   3'h0
`define SCPWM_RST_PERIOD 8'hff
`define SCPWM_RST_DUTY   8'h00
`define SCPWM_RST_PHASE  8'h00
`define SCPWM_RST_MODE   2'h0

// ----------------------------------------------------------------
// Timing: 125 ns oscillator period on a 10 ns clock divides down to 12 clocks (120 ns)
// ----------------------------------------------------------------
`define SCPWM_CLK_PS     10000
`define SCPWM_TOSC_PS    125000
`define SCPWM_OSC_DIV    (`SCPWM_TOSC_PS / `SCPWM_CLK_PS)
`define SCPWM_OSC_HALF   (`SCPWM_OSC_DIV / 2)

`endif

//--- hdl/scpwm_top.sv
// Purpose: System clock PWM with frequency sync, Wishbone slave
// Assumes: 100 MHz clk_i, oscillator tick every 12 clocks (120 ns)
// Notes:   Sleep and ce_i low both freeze the time base and pins
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "scpwm_regs.svh"

// Notes on behaviour
// - Period is (period limit plus one) oscillator periods times prescale.
// - Tick after counter equals limit clears counter and latches duty.
// - Output high for duty times oscillator period times prescale.
// - Duty buffer writable anytime, used only after the next latch.
// - Each period is high for the duty, then low for the rest.
// - Stand-alone, the waveform is the system clock output.
// - Duty is never changed cycle by cycle; it only caps converter duty.
// - Master also drives its clock and sync pulse onto shared pins.
// - Slave ORs sync with rollover; this latches duty and phase.
// - Slave delays clock start by phase times oscillator period times prescale.
// - Sleep stops the timer and freezes the time base; the bus and pin synchronisers keep running.
// - Clock output pin keeps its level throughout sleep.
module scpwm_top
(
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        sleep_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // System clock output
    output logic             clock_out_pin_o,
    // Shared clock pin, two-way
    input  wire logic        shared_clock_pin_i,
    output logic             shared_clock_pin_o,
    output logic             shared_clock_pin_oe_n_o,
    // Sync pin, two-way
    input  wire logic        sync_pin_i,
    output logic             sync_pin_o,
    output logic             sync_pin_oe_n_o
);
    // ------------------------------------------------------------
    // Registers and wires
    // ------------------------------------------------------------
    scpwm_pkg::scpwm_ctrl_s  timer_control_reg;
    logic [7:0]              period_limit_reg;
    logic [7:0]              duty_buffer_reg;
    logic [7:0]              phase_buffer_reg;
    logic [1:0]              mode_reg;
    logic [7:0]              base_counter_reg;
    logic [7:0]              base_counter_next;
    logic [7:0]              duty_active_reg;
    logic [7:0]              duty_active_next;
    logic [7:0]              phase_active_reg;
    logic [7:0]              phase_active_next;
    logic [7:0]              phase_cnt_reg;
    logic [7:0]              phase_cnt_next;
    scpwm_pkg::scpwm_state_e state_reg;
    scpwm_pkg::scpwm_state_e state_next;
    logic                    pwm_reg;
    logic                    pwm_next;
    logic                    sync_out_reg;
    logic                    sync_out_next;
    logic                    shclk_reg;
    logic [3:0]              osc_cnt_reg;
    logic                    ext_clk_prev_reg;
    logic                    ext_sync_prev_reg;
    logic                    ack_reg;
    logic [31:0]             dat_reg;

    logic        en;
    logic        is_master;
    logic        is_slave;
    logic        int_osc_tick;
    logic        ext_clk_lvl;
    logic        ext_sync_lvl;
    logic        ext_clk_rise;
    logic        sync_evt;
    logic        osc_tick;
    logic        tick;
    logic        at_limit;
    logic        rollover;
    logic        bus_req;
    logic        wr_en;
    logic        hi_adr_zero;
    logic        hit_ctrl;
    logic        hit_period;
    logic        hit_duty;
    logic        hit_phase;
    logic        hit_mode;
    logic        hit_stat;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // Enables and mode decode
    // ------------------------------------------------------------
    // Sleep only halts the time base; the bus still answers
    assign en        = ce_i && !sleep_i;
    assign is_master = (mode_reg == scpwm_pkg::MODE_MASTER);
    assign is_slave  = (mode_reg == scpwm_pkg::MODE_SLAVE);

    // ------------------------------------------------------------
    // Pin inputs
    // ------------------------------------------------------------
    scpwm_pin_sync u_clk_sync
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .pin_i   (shared_clock_pin_i),
        .level_o (ext_clk_lvl)
    );

    scpwm_pin_sync u_sync_sync
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .pin_i   (sync_pin_i),
        .level_o (ext_sync_lvl)
    );

    assign ext_clk_rise = ext_clk_lvl && !ext_clk_prev_reg;
    assign sync_evt     = is_slave && ext_sync_lvl && !ext_sync_prev_reg;

    // ------------------------------------------------------------
    // Oscillator tick and prescaler
    // ------------------------------------------------------------
    assign int_osc_tick = (osc_cnt_reg == 4'(`SCPWM_OSC_DIV - 1));
    // Slave counts the master's clock edges instead of its own
    assign osc_tick     = is_slave ? ext_clk_rise : int_osc_tick;

    scpwm_prescaler u_prescaler
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .en_i       (en),
        .run_i      (timer_control_reg.run),
        .ps_sel_i   (timer_control_reg.ps_sel),
        .osc_tick_i (osc_tick),
        .tick_o     (tick)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_cnt_reg       <= 4'h0;
            shclk_reg         <= 1'b0;
            ext_clk_prev_reg  <= 1'b0;
            ext_sync_prev_reg <= 1'b0;
        end
        else if (en)
        begin
            osc_cnt_reg       <= int_osc_tick ? 4'h0 : osc_cnt_reg + 4'h1;
            shclk_reg         <= (osc_cnt_reg < 4'(`SCPWM_OSC_HALF));
            ext_clk_prev_reg  <= ext_clk_lvl;
            ext_sync_prev_reg <= ext_sync_lvl;
        end
    end

    // ------------------------------------------------------------
    // Time base and waveform
    // ------------------------------------------------------------
    assign at_limit = (base_counter_reg == period_limit_reg);
    assign rollover = tick && at_limit;

    always_comb
    begin
        state_next        = state_reg;
        base_counter_next = base_counter_reg;
        duty_active_next  = duty_active_reg;
        phase_active_next = phase_active_reg;
        phase_cnt_next    = phase_cnt_reg;
        unique case (state_reg)
            scpwm_pkg::ST_STOP:
            begin
                base_counter_next = 8'h00;
                if (timer_control_reg.run)
                    state_next = scpwm_pkg::ST_RUN;
            end
            scpwm_pkg::ST_RUN, scpwm_pkg::ST_PHASE:
            begin
                if (!timer_control_reg.run)
                    state_next = scpwm_pkg::ST_STOP;
                else if (sync_evt)
                begin
                    // Master sync restarts the period after the phase delay
                    base_counter_next = 8'h00;
                    duty_active_next  = duty_buffer_reg;
                    phase_active_next = phase_buffer_reg;
                    phase_cnt_next    = phase_buffer_reg;
                    state_next        = (phase_buffer_reg == 8'h00)
                                        ? scpwm_pkg::ST_RUN : scpwm_pkg::ST_PHASE;
                end
                else if (state_reg == scpwm_pkg::ST_PHASE)
                begin
                    if (tick)
                    begin
                        phase_cnt_next = phase_cnt_reg - 8'h01;
                        if (phase_cnt_reg <= 8'h01)
                            state_next = scpwm_pkg::ST_RUN;
                    end
                end
                else if (rollover)
                begin
                    base_counter_next = 8'h00;
                    duty_active_next  = duty_buffer_reg;
                    if (is_slave)
                        phase_active_next = phase_buffer_reg;
                end
                else if (tick)
                    base_counter_next = base_counter_reg + 8'h01;
            end
            default:
                state_next = scpwm_pkg::ST_STOP;
        endcase
    end

    // High for the first duty counts of each period, then low
    assign pwm_next = (state_next == scpwm_pkg::ST_RUN)
                      && (base_counter_next < duty_active_next);
    assign sync_out_next = is_master && (state_next == scpwm_pkg::ST_RUN)
                           && (base_counter_next == 8'h00);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg        <= scpwm_pkg::ST_STOP;
            base_counter_reg <= 8'h00;
            duty_active_reg  <= `SCPWM_RST_DUTY;
            phase_active_reg <= `SCPWM_RST_PHASE;
            phase_cnt_reg    <= 8'h00;
            pwm_reg          <= 1'b0;
            sync_out_reg     <= 1'b0;
        end
        else if (en)
        begin
            state_reg        <= state_next;
            base_counter_reg <= base_counter_next;
            duty_active_reg  <= duty_active_next;
            phase_active_reg <= phase_active_next;
            phase_cnt_reg    <= phase_cnt_next;
            pwm_reg          <= pwm_next;
            sync_out_reg     <= sync_out_next;
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    // Frozen flops keep the driven level through sleep
    assign clock_out_pin_o         = pwm_reg;
    assign shared_clock_pin_o      = shclk_reg;
    assign shared_clock_pin_oe_n_o = !is_master;
    // A zero period limit keeps sync high, so slaves see no edge
    assign sync_pin_o              = sync_out_reg;
    assign sync_pin_oe_n_o         = !is_master;

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    assign bus_req     = cyc_i && stb_i;
    assign wr_en       = bus_req && we_i && ack_reg && sel_i[0];
    assign hi_adr_zero = (adr_i[31:8] == 24'h000000);
    assign hit_ctrl    = hi_adr_zero && (adr_i[7:0] == `SCPWM_OFS_CTRL);
    assign hit_period  = hi_adr_zero && (adr_i[7:0] == `SCPWM_OFS_PERIOD);
    assign hit_duty    = hi_adr_zero && (adr_i[7:0] == `SCPWM_OFS_DUTY);
    assign hit_phase   = hi_adr_zero && (adr_i[7:0] == `SCPWM_OFS_PHASE);
    assign hit_mode    = hi_adr_zero && (adr_i[7:0] == `SCPWM_OFS_MODE);
    assign hit_stat    = hi_adr_zero && (adr_i[7:0] == `SCPWM_OFS_STAT);

    assign rd_mux = hit_ctrl   ? {29'h0, timer_control_reg} :
                    hit_period ? {24'h0, period_limit_reg} :
                    hit_duty   ? {24'h0, duty_buffer_reg} :
                    hit_phase  ? {24'h0, phase_buffer_reg} :
                    hit_mode   ? {30'h0, mode_reg} :
                    hit_stat   ? {22'h0, (state_reg == scpwm_pkg::ST_PHASE),
                                  pwm_reg, base_counter_reg} :
                    32'h0;

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end
        else if (ce_i)
        begin
            ack_reg <= bus_req && !ack_reg;
            dat_reg <= (bus_req && !ack_reg && !we_i) ? rd_mux : dat_reg;
        end
    end

    // Duty buffer takes writes at any time; only the latch uses it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_control_reg <= `SCPWM_RST_CTRL;
            period_limit_reg  <= `SCPWM_RST_PERIOD;
            duty_buffer_reg   <= `SCPWM_RST_DUTY;
            phase_buffer_reg  <= `SCPWM_RST_PHASE;
            mode_reg          <= `SCPWM_RST_MODE;
        end
        else if (ce_i && wr_en)
        begin
            if (hit_ctrl)
                timer_control_reg <= dat_i[2:0];
            if (hit_period)
                period_limit_reg <= dat_i[7:0];
            if (hit_duty)
                duty_buffer_reg <= dat_i[7:0];
            if (hit_phase)
                phase_buffer_reg <= dat_i[7:0];
            if (hit_mode)
                mode_reg <= dat_i[1:0];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_roll;
        en && state_reg == scpwm_pkg::ST_RUN && timer_control_reg.run
        && !sync_evt && rollover;
    endsequence

    chk_roll_clear: assert property (s_roll |=> base_counter_reg == 8'h00)
        else $error("counter not cleared at rollover");
    chk_duty_latch: assert property (s_roll |=> duty_active_reg == $past(duty_buffer_reg))
        else $error("duty not latched at rollover");
    chk_duty_hold: assert property (!rollover && !sync_evt |=> $stable(duty_active_reg))
        else $error("active duty changed between latches");
    chk_out_high: assert property (en && state_next == scpwm_pkg::ST_RUN
        && base_counter_next < duty_active_next |=> clock_out_pin_o)
        else $error("output low inside duty");
    chk_sleep_freeze: assert property (sleep_i |=> $stable(base_counter_reg)
        && $stable(clock_out_pin_o) && $stable(state_reg))
        else $error("state moved during sleep");
    chk_master_pins: assert property (is_master |-> !shared_clock_pin_oe_n_o
        && !sync_pin_oe_n_o)
        else $error("master not driving shared pins");
    chk_slave_latch: assert property (en && sync_evt && timer_control_reg.run
        && state_reg != scpwm_pkg::ST_STOP
        |=> phase_active_reg == $past(phase_buffer_reg))
        else $error("sync did not latch phase");
    chk_phase_low: assert property (en && state_reg == scpwm_pkg::ST_PHASE
        && !tick && !sync_evt |=> !clock_out_pin_o)
        else $error("output high during phase delay");
    chk_run_gate: assert property (!timer_control_reg.run |-> !tick)
        else $error("tick while timer stopped");
endmodule
